// ==== adc_sequencing_control.sv ====
// Our own choices: the plain strobed port and the register offsets.
`include "adc_seq_defs.svh"
//
// Contract
// - Converter-on bit powers the converter
// - Idle-stop halts converter during idle mode
// - Resolution bit picks 12-bit or 10-bit
// - Ten-bit result formats: integer or signed
// - Twelve-bit result formats: integer or signed
// - Code 111 auto-converts after counter
// - Code 010 timer3 compare starts conversion
// - Code 001 external irq edge starts conversion
// - Code 000 sample clear starts conversion
// - Hardware sets and clears sample, done bits
// - Simultaneous sampling by channel-count field
// - Simultaneous bit reads zero in 12-bit
// - Scan-select bits choose scanned inputs
// - Absent selected input converts low reference
// - Pin bit one: digital, mux grounded
// - Pin bit zero: analog, read disabled
// - Pin bits ineffective where input absent
// - Power-off forces all pins digital
// - Unimplemented bits ignore writes, read zero
module adc_sequencing_control #(
  parameter logic [12:0] INPUT_PRESENT = 13'h1FFF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic idle_mode,
  input wire logic converter_power_off,
  input wire logic external_irq_zero,
  input wire logic timer3_compare,
  input wire logic conversion_complete,
  input wire logic [11:0] raw_result,
  output adc_seq_pkg::core_cmd_s core_cmd,
  output logic [12:0] scan_enable,
  output logic [12:0] scan_low_reference,
  output adc_seq_pkg::pin_cfg_s pin_cfg,
  output logic [15:0] result_data,
  output logic result_valid
);

  // ==========================================================
  // Register state
  // ==========================================================
  logic [15:0] ctrl;
  logic [12:0] scan_select;
  logic [12:0] pin_digital_select;
  logic [1:0] channel_count_select;
  logic sample_active;
  logic done;
  adc_seq_pkg::seq_state_e state;
  logic [7:0] sample_count;
  logic irq_prev;
  logic [15:0] next_result;

  wire logic wr_ctrl = reg_write && (reg_addr == `OFF_CTRL_ONE);
  wire logic converter_on = ctrl[`BIT_CONVERTER_ON];
  wire logic idle_stop = ctrl[`BIT_IDLE_STOP];
  wire logic resolution_select = ctrl[`BIT_RESOLUTION];
  wire logic [1:0] output_format = ctrl[`POS_FORMAT_LO +: 2];
  wire logic [2:0] conversion_trigger_select = ctrl[`POS_TRIGGER_LO +: 3];
  wire logic auto_sample = ctrl[`BIT_AUTO_SAMPLE];
  // The simultaneous bit is hidden while 12-bit mode is chosen.
  wire logic simultaneous_sample = ctrl[`BIT_SIMSAMPLE] & ~resolution_select;
  // Converter runs only when on, not powered off, and not stopped by idle.
  wire logic running = converter_on && !converter_power_off
                       && !(idle_stop && idle_mode);
  wire logic irq_edge = external_irq_zero && !irq_prev;

  // Software writes a sample clear while sampling under code 000.
  wire logic sw_sample_clear = wr_ctrl && !reg_wdata[`BIT_SAMPLE_ACTIVE] && sample_active;

  // Conversion trigger selection.
  logic trigger;
  always_comb begin
    case (conversion_trigger_select)
      `TRIG_MANUAL: trigger = sw_sample_clear;
      `TRIG_EXT_IRQ: trigger = irq_edge;
      `TRIG_TIMER3: trigger = timer3_compare;
      `TRIG_AUTO: trigger = (sample_count >= 8'(`AUTO_SAMPLE_CYC));
      default: trigger = 1'b0; // Reserved codes never trigger.
    endcase
  end

  // ==========================================================
  // Control register one, writable fields only
  // ==========================================================
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `RST_CTRL_ONE;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata & `CTRL_WR_MASK;
    end
  end

  // Scan select, pin configuration and channel-count registers.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scan_select <= `RST_SEL;
      pin_digital_select <= `RST_SEL;
      channel_count_select <= 2'h0;
    end else if (reg_write) begin
      if (reg_addr == `OFF_SCAN_SEL) begin
        scan_select <= reg_wdata[12:0];
      end
      if (reg_addr == `OFF_PIN_CFG) begin
        pin_digital_select <= reg_wdata[12:0];
      end
      if (reg_addr == `OFF_STATUS) begin
        channel_count_select <= reg_wdata[`POS_CHCOUNT_LO +: 2];
      end
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Sample opens by software set or auto-sample; trigger ends it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= adc_seq_pkg::ST_OFF;
      sample_active <= 1'b0;
      sample_count <= 8'h00;
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= external_irq_zero;
      case (state)
        adc_seq_pkg::ST_OFF: begin
          sample_active <= 1'b0;
          sample_count <= 8'h00;
          if (running) begin
            state <= adc_seq_pkg::ST_HOLD;
          end
        end
        adc_seq_pkg::ST_HOLD: begin
          sample_count <= 8'h00;
          if (!running) begin
            state <= adc_seq_pkg::ST_OFF;
          end else if (auto_sample || (wr_ctrl && reg_wdata[`BIT_SAMPLE_ACTIVE])) begin
            sample_active <= 1'b1;
            state <= adc_seq_pkg::ST_SAMPLE;
          end
        end
        adc_seq_pkg::ST_SAMPLE: begin
          if (sample_count != 8'hFF) begin
            sample_count <= sample_count + 8'h01;
          end
          if (!running) begin
            state <= adc_seq_pkg::ST_OFF;
          end else if (trigger) begin
            sample_active <= 1'b0;
            state <= adc_seq_pkg::ST_CONVERT;
          end
        end
        adc_seq_pkg::ST_CONVERT: begin
          if (!running) begin
            state <= adc_seq_pkg::ST_OFF;
          end else if (conversion_complete) begin
            state <= adc_seq_pkg::ST_HOLD;
          end
        end
        default: state <= adc_seq_pkg::ST_OFF;
      endcase
    end
  end

  // Done flag: completion sets it and wins over a software clear.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else if (state == adc_seq_pkg::ST_CONVERT && conversion_complete && running) begin
      done <= 1'b1;
    end else if (state == adc_seq_pkg::ST_HOLD && running
                 && (auto_sample || (wr_ctrl && reg_wdata[`BIT_SAMPLE_ACTIVE]))) begin
      done <= 1'b0;
    end else if (wr_ctrl && !reg_wdata[`BIT_DONE]) begin
      done <= 1'b0;
    end
  end

  // ==========================================================
  // Result formatting
  // ==========================================================
  always_comb begin
    next_result = 16'h0000;
    if (resolution_select) begin
      if (output_format == 2'h1) begin
        next_result = {{4{~raw_result[11]}}, raw_result[11:0]};
      end else begin
        next_result = {4'h0, raw_result[11:0]};
      end
    end else begin
      if (output_format == 2'h1) begin
        next_result = {{6{~raw_result[9]}}, raw_result[9:0]};
      end else begin
        next_result = {6'h00, raw_result[9:0]};
      end
    end
  end

  // Result is captured at conversion end.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      result_data <= 16'h0000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (state == adc_seq_pkg::ST_CONVERT && conversion_complete && running) begin
        result_data <= next_result;
        result_valid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Core command and pin steering
  // ==========================================================
  always_comb begin
    core_cmd.power_up = running;
    core_cmd.sample = sample_active;
    core_cmd.start_convert = (state == adc_seq_pkg::ST_CONVERT);
    core_cmd.twelve_bit = resolution_select;
    core_cmd.simultaneous = simultaneous_sample;
    // Twelve-bit mode is single channel.
    core_cmd.channel_count = resolution_select ? 2'h0 : channel_count_select;
  end

  // Per-input scan and pin mode decisions.
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_input
      assign scan_enable[gi] = scan_select[gi];
      // Selected but absent input converts the low reference.
      assign scan_low_reference[gi] = scan_select[gi] & ~INPUT_PRESENT[gi];
      // Absent inputs and power-off force digital mode.
      assign pin_cfg.digital_mode[gi] = converter_power_off || !INPUT_PRESENT[gi]
                                        || pin_digital_select[gi];
      assign pin_cfg.mux_to_ground[gi] = !converter_power_off && INPUT_PRESENT[gi]
                                         && pin_digital_select[gi];
    end
  endgenerate

  // ==========================================================
  // Read port, data in the cycle after the strobe
  // ==========================================================
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        `OFF_CTRL_ONE: reg_rdata <= {ctrl[15:4], simultaneous_sample, ctrl[2],
                                     sample_active, done};
        `OFF_SCAN_SEL: reg_rdata <= {3'h0, scan_select};
        `OFF_PIN_CFG: reg_rdata <= {3'h0, pin_digital_select};
        `OFF_STATUS: reg_rdata <= {12'h000, state};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // adc_sequencing_control

// ==== adc_seq_defs.svh ====
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
// Register offsets on the plain register port.
`define OFF_CTRL_ONE 4'h0
`define OFF_SCAN_SEL 4'h2
`define OFF_PIN_CFG 4'h4
`define OFF_STATUS 4'h6
// Control register one field positions.
`define BIT_CONVERTER_ON 15
`define BIT_IDLE_STOP 13
`define BIT_RESOLUTION 10
`define POS_FORMAT_LO 8
`define POS_TRIGGER_LO 5
`define BIT_SIMSAMPLE 3
`define BIT_AUTO_SAMPLE 2
`define BIT_SAMPLE_ACTIVE 1
`define BIT_DONE 0
// Channel-count field position in the status and option register.
`define POS_CHCOUNT_LO 0
// Reset values.
`define RST_CTRL_ONE 16'h0000
`define RST_SEL 13'h0000
// Writable field masks.
`define CTRL_WR_MASK 16'hA7EE
`define INPUT_MASK 13'h1FFF
// Trigger codes.
`define TRIG_MANUAL 3'h0
`define TRIG_EXT_IRQ 3'h1
`define TRIG_TIMER3 3'h2
`define TRIG_AUTO 3'h7
// Auto-convert sampling time and conversion time.
`define AUTO_SAMPLE_NS 320
`define AUTO_SAMPLE_CYC ((`AUTO_SAMPLE_NS + 9) / 10)
`define CONV_DONE_WAIT_CYC 8'h40
`endif

// ==== adc_seq_pkg.sv ====
package adc_seq_pkg;
  // Sequencer states.
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_HOLD = 4'b1000
  } seq_state_e;
  // Command to the analog core.
  typedef struct packed {
    logic power_up;
    logic sample;
    logic start_convert;
    logic twelve_bit;
    logic simultaneous;
    logic [1:0] channel_count;
  } core_cmd_s;
  // Pin configuration towards the pads.
  typedef struct packed {
    logic [12:0] digital_mode;
    logic [12:0] mux_to_ground;
  } pin_cfg_s;
endpackage

// ==== adc_seq_checker.sv ====
// ==========
// Port checks.
module adc_seq_checker #(
  parameter logic [12:0] INPUT_PRESENT = 13'h1FFF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic converter_power_off,
  input wire logic conversion_complete,
  input wire adc_seq_pkg::core_cmd_s core_cmd,
  input wire logic [12:0] scan_enable,
  input wire logic [12:0] scan_low_reference,
  input wire adc_seq_pkg::pin_cfg_s pin_cfg,
  input wire logic result_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // A finished conversion gives exactly one result strobe.
  sequence conv_end_s;
    core_cmd.start_convert && conversion_complete && core_cmd.power_up;
  endsequence
  sequence strobe_once_s;
    result_valid ##1 !result_valid;
  endsequence
  a_result_after_end:
    assert property (conv_end_s |=> strobe_once_s) else $error("result strobe missing");
  a_result_has_cause:
    assert property (result_valid |-> $past(conversion_complete)) else $error("stray result");
  a_read_data_idle:
    assert property (!$past(reg_read) |-> reg_rdata == 16'h0000) else $error("stray read data");
  a_absent_low_ref:
    assert property (scan_low_reference == (scan_enable & ~INPUT_PRESENT))
      else $error("low reference select wrong");
  a_off_all_digital:
    assert property (converter_power_off |-> pin_cfg.digital_mode == 13'h1FFF)
      else $error("pins not digital in power off");
  a_digital_mux_ground:
    assert property (!converter_power_off |->
      ((pin_cfg.mux_to_ground ^ pin_cfg.digital_mode) & INPUT_PRESENT) == 13'h0000)
      else $error("mux ground mismatch");
  a_twelve_one_chan:
    assert property (core_cmd.twelve_bit |-> !core_cmd.simultaneous && core_cmd.channel_count == 2'h0)
      else $error("twelve bit not single channel");
  a_sample_ends_convert:
    assert property ($fell(core_cmd.sample) && core_cmd.power_up |-> core_cmd.start_convert)
      else $error("sampling ended without conversion");
endmodule // adc_seq_checker

bind adc_sequencing_control adc_seq_checker #(.INPUT_PRESENT(INPUT_PRESENT)) u_adc_seq_checker (
  .sys_clk(sys_clk), .resetn(resetn), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .converter_power_off(converter_power_off), .conversion_complete(conversion_complete),
  .core_cmd(core_cmd), .scan_enable(scan_enable), .scan_low_reference(scan_low_reference),
  .pin_cfg(pin_cfg), .result_valid(result_valid));

// ==== adc_core_model.sv ====
// ==========
// Converter core stand-in.
module adc_core_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire adc_seq_pkg::core_cmd_s core_cmd,
  input wire logic [3:0] lat,
  input wire logic [11:0] value,
  output logic conversion_complete,
  output logic [11:0] raw_result
);
  logic [3:0] cnt;
  // Finishes a conversion lat+1 cycles after the start command appears.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      conversion_complete <= 1'b0;
    end else begin
      conversion_complete <= core_cmd.start_convert && !conversion_complete && cnt == lat;
      cnt <= (core_cmd.start_convert && !conversion_complete && cnt != lat) ? cnt + 4'h1 : 4'h0;
    end
  end
  // The result is only valid with the strobe; otherwise it shows junk.
  assign raw_result = conversion_complete ? value : ~value;
endmodule // adc_core_model

// ==== adc_sequencing_control_test.sv ====
`include "adc_seq_defs.svh"
// ==========
// Bench top.
module adc_sequencing_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] PRESENT = 13'h0FFF;
  logic sys_clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, idle_mode = 1'b0;
  logic converter_power_off = 1'b0, external_irq_zero = 1'b0, timer3_compare = 1'b0;
  logic [3:0] reg_addr = 4'h0, lat = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, result_data, got;
  logic [11:0] value = 12'h000, raw_result;
  logic [12:0] scan_enable, scan_low_reference;
  logic conversion_complete, result_valid;
  adc_seq_pkg::core_cmd_s core_cmd;
  adc_seq_pkg::pin_cfg_s pin_cfg;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rnd = 32'h81377CDF;
  logic [15:0] exp_q[$];
  logic [2:0] trigs[4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  // Clock at 100 MHz.
  always #5 sys_clk = ~sys_clk;
  adc_sequencing_control #(.INPUT_PRESENT(PRESENT)) u_adc_sequencing_control (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
    .converter_power_off(converter_power_off), .external_irq_zero(external_irq_zero),
    .timer3_compare(timer3_compare), .conversion_complete(conversion_complete),
    .raw_result(raw_result), .core_cmd(core_cmd), .scan_enable(scan_enable),
    .scan_low_reference(scan_low_reference), .pin_cfg(pin_cfg), .result_data(result_data),
    .result_valid(result_valid));
  adc_core_model u_adc_core_model (.sys_clk(sys_clk), .resetn(resetn), .core_cmd(core_cmd),
    .lat(lat), .value(value), .conversion_complete(conversion_complete), .raw_result(raw_result));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Expected formatted result.
  function automatic logic [15:0] fmt(input logic [11:0] r, input logic t, input logic [1:0] f);
    if (t) return (f == 2'h1) ? {{4{~r[11]}}, r} : {4'h0, r};
    return (f == 2'h1) ? {{6{~r[9]}}, r[9:0]} : {6'h00, r[9:0]};
  endfunction
  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    got = reg_rdata;
  endtask
  // One sample and conversion with a given resolution, format and trigger.
  task automatic conv(input logic t, input logic [1:0] f, input logic [2:0] s);
    logic [15:0] cfg;
    int n;
    cfg = {1'b1, 4'h0, t, f, s, 5'h00};
    rnd = xs(rnd);
    wr(`OFF_CTRL_ONE, cfg);
    value <= rnd[11:0];
    lat <= rnd[15:12];
    repeat (2) @(posedge sys_clk);
    wr(`OFF_CTRL_ONE, cfg | 16'h0002);
    repeat (4) @(negedge sys_clk);
    chk("sampling", {13'h0000, 2'h2, t}, 16'({core_cmd.sample, core_cmd.start_convert, core_cmd.twelve_bit}));
    @(posedge sys_clk);
    if (s == 3'h0) wr(`OFF_CTRL_ONE, cfg);
    external_irq_zero <= (s == 3'h1);
    timer3_compare <= (s == 3'h2);
    n = 4;
    while (core_cmd.start_convert !== 1'b1 && n < 80) begin
      @(posedge sys_clk);
      timer3_compare <= 1'b0;
      #1 n++;
    end
    chk("trigger delay", 16'h0001, 16'((s == 3'h7) ? (n >= 32 && n <= 34) : (n <= 8)));
    n = 0;
    while (result_valid !== 1'b1 && n < 40) begin
      if (conversion_complete === 1'b1) exp_q.push_back(fmt(raw_result, t, f));
      @(posedge sys_clk);
      #1 n++;
    end
    chk("result", (exp_q.size() != 0) ? exp_q.pop_front() : 16'hXXXX, result_data);
    @(posedge sys_clk);
    external_irq_zero <= 1'b0;
    rd(`OFF_CTRL_ONE);
    chk("status", (cfg & `CTRL_WR_MASK) | 16'h0001, got);
    wr(`OFF_CTRL_ONE, 16'h0000);
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(4'(2 * i + (i / 4) * 2));
      chk("reset or unmapped", (i == 3) ? 16'h0001 : 16'h0000, got);
    end
    wr(`OFF_SCAN_SEL, 16'hFFFF);
    rd(`OFF_SCAN_SEL);
    chk("scan", 16'h1FFF, got);
    chk("scan enable", 16'h1FFF, 16'(scan_enable));
    chk("low ref", {3'h0, ~PRESENT}, 16'(scan_low_reference));
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      wr(`OFF_PIN_CFG, rnd[15:0]);
      converter_power_off <= rnd[16];
      rd(`OFF_PIN_CFG);
      chk("pin cfg", {3'h0, rnd[12:0]}, got);
      chk("digital", rnd[16] ? 16'h1FFF : {3'h0, rnd[12:0] | ~PRESENT}, 16'(pin_cfg.digital_mode));
      chk("mux ground", rnd[16] ? 16'h0000 : {3'h0, rnd[12:0] & PRESENT}, 16'(pin_cfg.mux_to_ground));
    end
    @(posedge sys_clk);
    converter_power_off <= 1'b0;
    for (int i = 0; i < 8; i++) conv(i[2], i[1:0], trigs[i[1:0]]);
    wr(`OFF_CTRL_ONE, 16'hA000);
    idle_mode <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("idle stop", 16'h0000, 16'(core_cmd.power_up));
    wr(`OFF_CTRL_ONE, 16'h8000);
    repeat (2) @(negedge sys_clk);
    chk("idle run", 16'h0001, 16'(core_cmd.power_up));
    @(posedge sys_clk);
    idle_mode <= 1'b0;
    wr(`OFF_STATUS, 16'h0002);
    wr(`OFF_CTRL_ONE, 16'h8408);
    rd(`OFF_CTRL_ONE);
    chk("twelve sim", 16'h8400, got);
    wr(`OFF_CTRL_ONE, 16'h8008);
    rd(`OFF_CTRL_ONE);
    chk("sim cmd", 16'h0006, 16'({core_cmd.simultaneous, core_cmd.channel_count}));
    stop_test();
  end
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end
endmodule // adc_sequencing_control_test
